// ===== design/reset_source_pkg.sv
// Package for the reset source controller: register map, codes, timings.
// Assumes a 125 MHz system clock on hclk.
package reset_source_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_FUNC_CTRL = 8'h00;
	localparam logic [7:0] OFF_CAUSE = 8'h04;
	localparam logic [7:0] OFF_SUPPLY_CTRL = 8'h08;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
	localparam logic [7:0] OFF_MODE = 8'h10;

	// ---------------------------------------------------------------
	// Codes and reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] FUNC_SHARED_IO = 8'h55;
	localparam logic [7:0] FUNC_EXT_PIN = 8'hAA;
	localparam logic [7:0] FUNC_RESET_VAL = 8'h55;
	localparam logic [7:0] SUPPLY_RESET_VAL = 8'h66;
	localparam logic [7:0] SUPPLY_TH_A = 8'h66;
	localparam logic [7:0] SUPPLY_TH_B = 8'h55;
	localparam logic [7:0] SUPPLY_TH_C = 8'h33;
	localparam logic [7:0] SUPPLY_TH_D = 8'h99;
	localparam logic [7:0] SUPPLY_TH_E = 8'hAA;
	localparam logic [7:0] SUPPLY_OFF = 8'hF0;
	localparam logic [7:0] PORT_RESET_VAL = 8'hFF;

	// Cause flag bit positions.
	localparam int FLAG_WDOG = 0;
	localparam int FLAG_SUPPLY_CTRL = 1;
	localparam int FLAG_SUPPLY = 2;
	localparam int FLAG_PIN_CTRL = 3;
	localparam int FLAG_W = 4;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 8000;
	localparam int SOFT_RESET_DELAY_NS = 100;
	localparam int SOFT_RESET_CYC =
		(SOFT_RESET_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int QUALIFY_TIME_NS = 120;
	localparam int QUALIFY_CYC =
		(QUALIFY_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int START_DELAY_US = 1000;
	localparam int START_CYC =
		(START_DELAY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Power modes given by the core.
	typedef enum logic [1:0] {
		MODE_FAST,
		MODE_SLOW,
		MODE_IDLE,
		MODE_SLEEP
	} power_mode_t;

	// Outputs that the reset tree hands to the core.
	typedef struct packed {
		logic sys_reset;
		logic pc_clear;
		logic [7:0] port_preset;
	} reset_out_t;

endpackage

// ===== design/reset_source_controller.sv
// Reset source controller: combines power-on, pin, watchdog, supply drop
// and control-register self resets; AHB-Lite register slave.
// Assumes hresetn is the power-on reset and all inputs are synchronous.
`timescale 1ns/1ps

module reset_source_controller #(
	parameter int START_CYCLES = reset_source_pkg::START_CYC
) (
	// Clock and power-on reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Pin and system status
	input wire logic ext_reset_pin_n,
	input wire logic supply_low,
	input wire logic watchdog_timeout,
	input wire logic [1:0] power_mode,
	// Reset outputs
	output reset_source_pkg::reset_out_t rst_out,
	output logic pin_is_reset,
	output logic irq
);

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	logic addr_ph;
	logic wr_q;
	logic rd_q;
	logic [7:0] addr_q;
	assign addr_ph = hsel & hready & htrans[1];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			addr_q <= 8'h00;
		end else begin
			wr_q <= addr_ph & hwrite;
			rd_q <= addr_ph & ~hwrite;
			addr_q <= addr_ph ? haddr[7:0] : addr_q;
		end
	end

	wire wr_func = wr_q & (addr_q == reset_source_pkg::OFF_FUNC_CTRL);
	wire wr_cause = wr_q & (addr_q == reset_source_pkg::OFF_CAUSE);
	wire wr_supply = wr_q & (addr_q == reset_source_pkg::OFF_SUPPLY_CTRL);
	wire wr_mask = wr_q & (addr_q == reset_source_pkg::OFF_IRQ_MASK);

	// ---------------------------------------------------------------
	// Registers and validity
	// ---------------------------------------------------------------
	logic [7:0] func_q;
	logic [7:0] supply_q;
	logic [3:0] cause_q;
	logic [3:0] mask_q;
	logic sys_rst_q;
	logic warm_q;

	wire func_ok = (func_q == reset_source_pkg::FUNC_SHARED_IO) |
		(func_q == reset_source_pkg::FUNC_EXT_PIN);
	wire supply_ok = (supply_q == reset_source_pkg::SUPPLY_TH_A) |
		(supply_q == reset_source_pkg::SUPPLY_TH_B) |
		(supply_q == reset_source_pkg::SUPPLY_TH_C) |
		(supply_q == reset_source_pkg::SUPPLY_TH_D) |
		(supply_q == reset_source_pkg::SUPPLY_TH_E) |
		(supply_q == reset_source_pkg::SUPPLY_OFF);
	wire pin_sel = (func_q == reset_source_pkg::FUNC_EXT_PIN);
	wire asleep = (power_mode == 2'(reset_source_pkg::MODE_IDLE)) |
		(power_mode == 2'(reset_source_pkg::MODE_SLEEP));
	wire monitor_on = supply_ok &
		(supply_q != reset_source_pkg::SUPPLY_OFF) & ~asleep;

	// ---------------------------------------------------------------
	// Source detection
	// ---------------------------------------------------------------
	logic pin_prev_q;
	logic [7:0] soft_cnt_q;
	logic [7:0] qual_cnt_q;
	wire pin_fall = pin_sel & pin_prev_q & ~ext_reset_pin_n;
	wire soft_due = (soft_cnt_q ==
		8'(reset_source_pkg::SOFT_RESET_CYC));
	wire supply_due = (qual_cnt_q ==
		8'(reset_source_pkg::QUALIFY_CYC));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_prev_q <= 1'b1;
			soft_cnt_q <= 8'h00;
			qual_cnt_q <= 8'h00;
		end else begin
			pin_prev_q <= ext_reset_pin_n;
			if (sys_rst_q || (func_ok && supply_ok))
				soft_cnt_q <= 8'h00;
			else if (!soft_due)
				soft_cnt_q <= soft_cnt_q + 8'h01;
			// Drop shorter than the qualify time is forgotten.
			if (!monitor_on || !supply_low || sys_rst_q)
				qual_cnt_q <= 8'h00;
			else if (!supply_due)
				qual_cnt_q <= qual_cnt_q + 8'h01;
		end
	end

	wire soft_fire = soft_due & ~sys_rst_q;
	wire supply_fire = supply_due & ~sys_rst_q;
	wire wdog_fire = watchdog_timeout & ~sys_rst_q;
	wire pin_fire = pin_fall & ~sys_rst_q;
	wire any_fire = soft_fire | supply_fire | wdog_fire | pin_fire;

	// ---------------------------------------------------------------
	// Control registers
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			func_q <= reset_source_pkg::FUNC_RESET_VAL;
			supply_q <= reset_source_pkg::SUPPLY_RESET_VAL;
			mask_q <= 4'h0;
		end else begin
			if ((soft_fire || supply_fire || pin_fire) && !wdog_fire)
				func_q <= reset_source_pkg::FUNC_RESET_VAL;
			else if (wr_func)
				func_q <= hwdata[7:0];
			// A genuine drop keeps the threshold; a bad code is repaired.
			if (soft_fire && !supply_ok)
				supply_q <= reset_source_pkg::SUPPLY_RESET_VAL;
			else if (wr_supply && !supply_fire)
				supply_q <= hwdata[7:0];
			if (wr_mask)
				mask_q <= hwdata[3:0];
		end
	end

	// ---------------------------------------------------------------
	// Cause flags: set wins over write-one clear
	// ---------------------------------------------------------------
	logic [3:0] cause_set;
	assign cause_set[reset_source_pkg::FLAG_PIN_CTRL] =
		soft_fire & ~func_ok;
	assign cause_set[reset_source_pkg::FLAG_SUPPLY] = supply_fire;
	assign cause_set[reset_source_pkg::FLAG_SUPPLY_CTRL] =
		soft_fire & ~supply_ok;
	assign cause_set[reset_source_pkg::FLAG_WDOG] = 1'b0;
	wire [3:0] cause_clr = wr_cause ? hwdata[3:0] : 4'h0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cause_q <= 4'h0;
		else
			cause_q <= (cause_q & ~cause_clr) | cause_set;
	end

	// ---------------------------------------------------------------
	// Reset hold and release
	// ---------------------------------------------------------------
	logic [31:0] hold_cnt_q;
	logic pin_wait_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sys_rst_q <= 1'b1;
			warm_q <= 1'b0;
			pin_wait_q <= 1'b0;
			hold_cnt_q <= 32'h0;
		end else if (any_fire) begin
			sys_rst_q <= 1'b1;
			warm_q <= wdog_fire & ~soft_fire & ~supply_fire & ~pin_fire;
			pin_wait_q <= pin_fire;
			hold_cnt_q <= 32'h0;
		end else if (sys_rst_q) begin
			// Pin reset holds while the pin is low, then start delay.
			if (pin_wait_q && !ext_reset_pin_n)
				hold_cnt_q <= 32'h0;
			else if (hold_cnt_q >= 32'(START_CYCLES - 1))
				sys_rst_q <= 1'b0;
			else
				hold_cnt_q <= hold_cnt_q + 32'h1;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	// Read data is selected from the address phase, so that it already
	// stands in the register when the data phase ends.
	logic [7:0] rdata;
	always_comb begin
		rdata = 8'h00;
		unique case (haddr[7:0])
			reset_source_pkg::OFF_FUNC_CTRL: rdata = func_q;
			reset_source_pkg::OFF_CAUSE: rdata = {4'h0, cause_q};
			reset_source_pkg::OFF_SUPPLY_CTRL: rdata = supply_q;
			reset_source_pkg::OFF_IRQ_MASK: rdata = {4'h0, mask_q};
			reset_source_pkg::OFF_MODE: rdata = {6'h00, power_mode};
			default: rdata = 8'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			rst_out.sys_reset <= 1'b1;
			rst_out.pc_clear <= 1'b1;
			rst_out.port_preset <= reset_source_pkg::PORT_RESET_VAL;
			pin_is_reset <= 1'b0;
			irq <= 1'b0;
		end else begin
			hrdata <= (addr_ph & ~hwrite) ? {24'h0, rdata} : hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			rst_out.sys_reset <= sys_rst_q & ~warm_q;
			rst_out.pc_clear <= sys_rst_q;
			rst_out.port_preset <= (sys_rst_q & ~warm_q) ?
				reset_source_pkg::PORT_RESET_VAL : 8'h00;
			pin_is_reset <= pin_sel;
			irq <= |(cause_q & mask_q);
		end
	end

endmodule

// ===== sim/reset_source_props.sv
// Port checker for the reset source controller.
// Assumes it is bound to each reset_source_controller instance.
`timescale 1ns/1ps
module reset_source_props #(
	parameter int START_CYCLES = 20
) (
	// Watched ports
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ext_reset_pin_n,
	input wire logic watchdog_timeout,
	input wire reset_source_pkg::reset_out_t rst_out,
	input wire logic pin_is_reset
);
	int hi_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hi_q <= 0;
		else if (rst_out.sys_reset)
			hi_q <= hi_q + 1;
		else
			hi_q <= 0;
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_preset_ff: assert property (
		rst_out.port_preset == (rst_out.sys_reset ? 8'hFF : 8'h00))
		else $error("port preset wrong");
	a_pc_follow: assert property (
		rst_out.sys_reset |-> rst_out.pc_clear)
		else $error("pc clear missing");
	a_pin_fall: assert property (
		pin_is_reset && $fell(ext_reset_pin_n) |-> ##[0:2] rst_out.sys_reset)
		else $error("pin reset missing");
	a_pin_ignored: assert property (
		!pin_is_reset && $fell(ext_reset_pin_n) && !rst_out.sys_reset
		|=> !rst_out.sys_reset) else $error("shared pin reset");
	a_hold_time: assert property (
		$fell(rst_out.sys_reset) |-> hi_q >= START_CYCLES - 2)
		else $error("reset released early");
	a_warm_pc: assert property (
		$rose(watchdog_timeout) |-> ##[0:2] rst_out.pc_clear)
		else $error("warm reset missing");
	a_warm_only: assert property (
		$rose(watchdog_timeout) && !rst_out.sys_reset
		|-> ##1 !rst_out.sys_reset [*2]) else $error("warm made full");
	a_sel_cleared: assert property (
		$rose(rst_out.sys_reset) |-> ##[0:8] !pin_is_reset)
		else $error("pin select kept");
endmodule
bind reset_source_controller reset_source_props #(
	.START_CYCLES(START_CYCLES)
) props_inst (.hclk(hclk), .hresetn(hresetn),
	.ext_reset_pin_n(ext_reset_pin_n),
	.watchdog_timeout(watchdog_timeout), .rst_out(rst_out),
	.pin_is_reset(pin_is_reset));

// ===== sim/ext_supply_model.sv
// Model of the external reset pin circuit and the supply monitor.
// Assumes callers set a length in cycles; lines change at hclk edges.
`timescale 1ns/1ps
module ext_supply_model (
	// Clock
	input wire logic hclk,
	// Lines to the controller
	output logic ext_reset_pin_n = 1'b1,
	output logic supply_low = 1'b0
);
	int pin_left = 0;
	int low_left = 0;
	// The pin has a pull-up, so a released pin reads high.
	always @(posedge hclk) begin
		ext_reset_pin_n <= (pin_left == 0);
		supply_low <= (low_left > 0);
		if (pin_left > 0)
			pin_left <= pin_left - 1;
		if (low_left > 0)
			low_left <= low_left - 1;
	end
	task automatic pin_low(input int n);
		pin_left = n;
	endtask
	task automatic drop(input int n);
		low_left = n;
	endtask
endmodule

// ===== sim/testbench.sv
// Self-checking bench: AHB-Lite register tasks and reset scenarios.
// Assumes the design is a zero-wait slave and START_CYCLES is 20.
`timescale 1ns/1ps
module testbench;
	localparam logic [7:0] A_FUNC = reset_source_pkg::OFF_FUNC_CTRL;
	localparam logic [7:0] A_CAUSE = reset_source_pkg::OFF_CAUSE;
	localparam logic [7:0] A_SUP = reset_source_pkg::OFF_SUPPLY_CTRL;
	localparam logic [7:0] A_MASK = reset_source_pkg::OFF_IRQ_MASK;
	logic hclk, hresetn, hwrite, watchdog_timeout, pin_n, low, hsel;
	logic [2:0] hsize;
	logic hreadyout, hresp, pin_is_reset, irq;
	logic [31:0] haddr, hwdata, hrdata, rd_s;
	logic [1:0] htrans, power_mode;
	reset_source_pkg::reset_out_t rst_out;
	int fails = 0;
	int checks = 0;
	reset_source_controller #(.START_CYCLES(20)) reset_source_controller_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .ext_reset_pin_n(pin_n), .supply_low(low),
		.watchdog_timeout(watchdog_timeout), .power_mode(power_mode),
		.rst_out(rst_out), .pin_is_reset(pin_is_reset), .irq(irq));
	ext_supply_model ext_supply_model_inst (.hclk(hclk),
		.ext_reset_pin_n(pin_n), .supply_low(low));
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	always @(posedge hclk) rd_s <= hrdata;
	task end_of_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic settle;
		@(posedge hclk);
		#1;
	endtask
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge hclk);
		htrans <= 2'h2;
		hsel <= 1'b1;
		hsize <= 3'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
		htrans <= 2'h0;
		hwdata <= d;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
		#1;
		r = rd_s;
		if (n >= 50) begin
			fails++;
			end_of_test;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(a, 1'b1, d, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
		logic [31:0] r;
		xfer(a, 1'b0, 32'h0, r);
		chk(s, e, r);
	endtask
	task automatic wt(input logic v);
		int n;
		for (n = 0; n < 300 && rst_out.sys_reset !== v; n++)
			settle;
		if (n == 300) begin
			fails++;
			end_of_test;
		end
	endtask
	task automatic quiet(input string s);
		int n;
		n = 0;
		repeat (45) begin
			settle;
			n += int'(rst_out.sys_reset === 1'b1);
		end
		chk(s, 32'h0, 32'(n));
	endtask
	initial begin
		hresetn = 1'b0;
		htrans = 2'h0;
		hsel = 1'b0;
		hsize = 3'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		watchdog_timeout = 1'b0;
		power_mode = 2'h0;
		repeat (5) settle;
		chk("preset", 32'hFF, 32'(rst_out.port_preset));
		chk("pc clear", 32'h1, 32'(rst_out.pc_clear));
		@(posedge hclk);
		hresetn <= 1'b1;
		wt(1'b0);
		rd(A_FUNC, 32'h55, "func");
		rd(A_SUP, 32'h66, "supply");
		wr(A_CAUSE, 32'hFFFF_FFFF);
		rd(A_CAUSE, 32'h0, "cause");
		rd(8'h20, 32'h0, "unmapped");
		wr(A_MASK, 32'hF);
		ext_supply_model_inst.pin_low(10);
		quiet("shared pin");
		wr(A_FUNC, 32'hAA);
		settle;
		chk("pin sel", 32'h1, 32'(pin_is_reset));
		@(posedge hclk);
		watchdog_timeout <= 1'b1;
		@(posedge hclk);
		watchdog_timeout <= 1'b0;
		quiet("warm");
		rd(A_FUNC, 32'hAA, "warm func");
		ext_supply_model_inst.pin_low(30);
		wt(1'b1);
		wt(1'b0);
		rd(A_FUNC, 32'h55, "func back");
		wr(A_FUNC, 32'h12);
		wt(1'b1);
		wt(1'b0);
		rd(A_CAUSE, 32'h8, "pin flag");
		chk("irq", 32'h1, 32'(irq));
		wr(A_CAUSE, 32'h8);
		rd(A_CAUSE, 32'h0, "flag clr");
		chk("irq off", 32'h0, 32'(irq));
		wr(A_SUP, 32'h55);
		ext_supply_model_inst.drop(10);
		quiet("short drop");
		ext_supply_model_inst.drop(30);
		wt(1'b1);
		wt(1'b0);
		rd(A_CAUSE, 32'h4, "drop flag");
		rd(A_SUP, 32'h55, "sup kept");
		wr(A_CAUSE, 32'hF);
		for (int m = 2; m < 4; m++) begin
			@(posedge hclk);
			power_mode <= 2'(m);
			ext_supply_model_inst.drop(30);
			quiet("low power");
		end
		@(posedge hclk);
		power_mode <= 2'h0;
		wr(A_SUP, 32'hF0);
		ext_supply_model_inst.drop(30);
		quiet("monitor off");
		wr(A_MASK, 32'h0);
		wr(A_SUP, 32'h12);
		wt(1'b1);
		wt(1'b0);
		rd(A_CAUSE, 32'h2, "sup flag");
		rd(A_SUP, 32'h66, "sup reset");
		chk("masked", 32'h0, 32'(irq));
		wr(A_MASK, 32'h2);
		settle;
		chk("unmasked", 32'h1, 32'(irq));
		end_of_test;
	end
endmodule
